//--- design/sds_consts.vh
// Purpose: constants of the scooter drive supervisor
// Assumes: voltages in 0.1 V units, delays in ms
// Notes: register offsets are byte addresses on the apb bus
`ifndef SDS_CONSTS_VH
`define SDS_CONSTS_VH

// clock and time base
`define SDS_PCLK_NS 8
`define SDS_MS_NS 1000000
`define SDS_BRK_CHK_MS 15'd100

// register byte offsets
`define SDS_OFS_CTRL 8'h00
`define SDS_OFS_VMAX 8'h04
`define SDS_OFS_OV 8'h08
`define SDS_OFS_UV 8'h0c
`define SDS_OFS_DLY 8'h10
`define SDS_OFS_STAT 8'h14
`define SDS_OFS_FLT 8'h18

// control register fields
`define SDS_CTL_MT_LSB 0
`define SDS_CTL_DT_LSB 2
`define SDS_CTL_BT_LSB 5
`define SDS_HI_LSB 16

// motor test selections
`define SDS_MT_NONE 2'h0
`define SDS_MT_OPEN 2'h1
`define SDS_MT_SHORT 2'h2
`define SDS_MT_ALL 2'h3

// brake test selections
`define SDS_BT_NONE 2'h0
`define SDS_BT_PRE 2'h1
`define SDS_BT_DRV 2'h2

// dead-time adjust range
`define SDS_DT_MAX 3'h4

// voltage limits and reset values, 0.1 V units
`define SDS_VMAX_LO 10'h014
`define SDS_VMAX_HI 10'h192
`define SDS_VMAX_RST 10'h120
`define SDS_OVW_LO 10'h0f0
`define SDS_OVW_HI 10'h12e
`define SDS_OVW_RST 10'h12e
`define SDS_OVR_LO 10'h12e
`define SDS_OVR_HI 10'h15c
`define SDS_OVR_RST 10'h156
`define SDS_UVS_LO 10'h0b4
`define SDS_UVS_HI 10'h142
`define SDS_UVS_RST 10'h0d2
`define SDS_UVE_LO 10'h0aa
`define SDS_UVE_HI 10'h0d2
`define SDS_UVE_RST 10'h0b4

// brake delays in ms
`define SDS_DLY_HI 15'h639c
`define SDS_ENG_RST 15'h07d0
`define SDS_REL_RST 15'h0000

// full throttle scale
`define SDS_FULL 8'hff

`endif

//--- design/sds_dly_timer.v
// Purpose: millisecond delay timer for brake engage and release
// Assumes: ms_tick is a one-cycle pulse once per millisecond
// Notes: first ms may be short by up to one tick period
`timescale 1ns/1ns
module sds_dly_timer (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// control
	input wire start,
	input wire [14:0] load_ms,
	input wire ms_tick,
	// status
	output wire done
);
	reg [14:0] cnt_ff; // remaining ms
	reg [14:0] nxt_cnt;

	// load on start, count down on each ms tick
	always @* begin
		nxt_cnt = cnt_ff;
		if (start) begin
			nxt_cnt = load_ms;
		end else if (ms_tick && cnt_ff != 15'h0000) begin
			nxt_cnt = cnt_ff - 15'h0001;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 15'h0000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// done is held off in the start cycle so a stale zero never leaks
	assign done = (cnt_ff == 15'h0000) && !start;
endmodule // sds_dly_timer

//--- design/sds_drive_sup.v
// Purpose: scooter drive supervisor with apb configuration
// Assumes: demand, stopped and vbat come from logic on pclk
// Notes: fault sense pins are asynchronous and are synchronised
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "sds_consts.vh"
module sds_drive_sup #(
	parameter MS_CYCLES = `SDS_MS_NS / `SDS_PCLK_NS
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	// drive inputs
	input wire [7:0] demand,
	input wire stopped,
	input wire [9:0] vbat,
	input wire [7:0] dt_calib,
	// fault sense pins
	input wire [3:0] flt_pin,
	// bridge and brake outputs
	output wire [9:0] motor_volt,
	output wire drive_en,
	output wire brake_release,
	output wire [7:0] dead_time,
	output wire motor_open_test,
	output wire motor_short_test,
	output wire brake_open_chk,
	output wire brake_short_chk
);
	// fsm states, one-hot
	localparam ST_PARK = 4'h1; // brake engaged, no drive
	localparam ST_REL = 4'h2; // brake released, drive withheld
	localparam ST_DRV = 4'h4; // driving
	localparam ST_NEUT = 4'h8; // zero demand, awaiting engage

	// configuration registers
	reg [1:0] mt_ff;
	reg [2:0] dt_ff;
	reg [1:0] bt_ff;
	reg [9:0] vmax_ff, ovw_ff, ovr_ff, uvs_ff, uve_ff;
	reg [14:0] eng_ff, rel_ff;
	reg [3:0] flt_ff; // motor open, motor short, brake open, brake short
	reg [31:0] rdata_ff;
	reg [3:0] st_ff;
	reg [3:0] nxt_st;

	// clamp a written value into its documented range
	function [9:0] clampv;
		input [9:0] v;
		input [9:0] lo;
		input [9:0] hi;
		begin
			clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	// apb decode; zero wait states, unmapped offsets answer with error
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire mapped = (paddr == `SDS_OFS_CTRL) || (paddr == `SDS_OFS_VMAX) ||
		(paddr == `SDS_OFS_OV) || (paddr == `SDS_OFS_UV) ||
		(paddr == `SDS_OFS_DLY) || (paddr == `SDS_OFS_STAT) ||
		(paddr == `SDS_OFS_FLT);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = rdata_ff;

	// synchronise fault pins, two flops per bit
	reg [3:0] sy1_ff, sy2_ff;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sy1_ff[gi] <= 1'b0;
					sy2_ff[gi] <= 1'b0;
				end else begin
					sy1_ff[gi] <= flt_pin[gi];
					sy2_ff[gi] <= sy1_ff[gi];
				end
			end
		end
	endgenerate

	// millisecond tick from pclk; a slow rate is an enable pulse
	reg [16:0] pre_ff;
	wire ms_tick = (pre_ff == 17'h00000);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 17'h00000;
		end else if (ms_tick) begin
			pre_ff <= MS_CYCLES[16:0] - 17'h00001;
		end else begin
			pre_ff <= pre_ff - 17'h00001;
		end
	end

	// throttle limit: linear in the under-voltage band, found by a
	// serial divider so no wide combinational divide is needed
	reg [17:0] rem_ff;
	reg [7:0] q_ff, ulim_ff;
	reg [3:0] dcnt_ff;
	wire [9:0] den = uvs_ff - uve_ff;
	wire [9:0] num = vbat - uve_ff;
	wire [17:0] dsh = {8'h00, den} << dcnt_ff[2:0];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_ff <= 18'h00000;
			q_ff <= 8'h00;
			ulim_ff <= `SDS_FULL;
			dcnt_ff <= 4'h8;
		end else if (dcnt_ff == 4'h8) begin
			// start a new division: (vbat - end) * 255 / (start - end)
			rem_ff <= {num, 8'h00} - {8'h00, num};
			q_ff <= 8'h00;
			dcnt_ff <= 4'h7;
		end else begin
			if (rem_ff >= dsh) begin
				rem_ff <= rem_ff - dsh;
			end
			q_ff[dcnt_ff[2:0]] <= (rem_ff >= dsh);
			if (dcnt_ff == 4'h0) begin
				// result is latched once all quotient bits are known
				ulim_ff <= (rem_ff >= dsh) ? (q_ff | 8'h01) : q_ff;
				dcnt_ff <= 4'h8;
			end else begin
				dcnt_ff <= dcnt_ff - 4'h1;
			end
		end
	end

	// battery based throttle limit
	reg [7:0] lim;
	always @* begin
		if (vbat >= ovr_ff) begin
			lim = 8'h00;
		end else if (vbat < uve_ff) begin
			lim = 8'h00;
		end else if (vbat < uvs_ff && den != 10'h000) begin
			lim = ulim_ff;
		end else begin
			lim = `SDS_FULL;
		end
		// over-voltage warning halves the allowed throttle
		if (vbat > ovw_ff) begin
			lim = {1'b0, lim[7:1]};
		end
	end

	// applied voltage: demand share of min(vmax, vbat)
	wire [7:0] dem_eff = (demand > lim) ? lim : demand;
	wire [9:0] vlim = (vbat < vmax_ff) ? vbat : vmax_ff;
	wire [17:0] prod = vlim * dem_eff;
	wire [17:0] sc = prod + (prod >> 8) + 18'h00001;
	wire [9:0] vout = (sc[17:8] > vlim) ? vlim : sc[17:8];
	reg [9:0] volt_ff;
	reg [7:0] dtime_ff;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			volt_ff <= 10'h000;
			dtime_ff <= 8'h00;
		end else begin
			// no voltage at all while drive is withheld
			volt_ff <= drive_en ? vout : 10'h000;
			// adjust adds to the calibrated dead-time
			dtime_ff <= dt_calib + {5'h00, dt_ff};
		end
	end
	assign motor_volt = volt_ff;
	assign dead_time = dtime_ff;

	// brake delay timers
	wire eng_done, rel_done;
	wire eng_start = (nxt_st == ST_NEUT) && (st_ff != ST_NEUT);
	wire rel_start = (nxt_st == ST_REL) && (st_ff != ST_REL);
	sds_dly_timer u_eng (
		.pclk(pclk),
		.presetn(presetn),
		.start(eng_start),
		.load_ms(eng_ff),
		.ms_tick(ms_tick),
		.done(eng_done)
	);
	sds_dly_timer u_rel (
		.pclk(pclk),
		.presetn(presetn),
		.start(rel_start),
		.load_ms(rel_ff),
		.ms_tick(ms_tick),
		.done(rel_done)
	);

	// park brake sequencing; any latched fault parks at once
	wire flt_any = (flt_ff != 4'h0);
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_PARK: begin
				if (demand != 8'h00 && !flt_any) begin
					nxt_st = ST_REL;
				end
			end
			ST_REL: begin
				if (demand == 8'h00) begin
					nxt_st = ST_NEUT;
				end else if (rel_done) begin
					nxt_st = ST_DRV;
				end
			end
			ST_DRV: begin
				if (demand == 8'h00 && stopped) begin
					nxt_st = ST_NEUT;
				end
			end
			ST_NEUT: begin
				if (demand != 8'h00) begin
					nxt_st = ST_DRV;
				end else if (eng_done) begin
					nxt_st = ST_PARK;
				end
			end
			default: begin
				nxt_st = ST_PARK;
			end
		endcase
		if (flt_any) begin
			nxt_st = ST_PARK;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_PARK;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign brake_release = (st_ff != ST_PARK);
	assign drive_en = (st_ff == ST_DRV) || (st_ff == ST_NEUT);

	// periodic brake check timer while the brake is released
	reg [14:0] per_ff;
	wire per_hit = ms_tick && (per_ff == 15'h0000) && brake_release;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_ff <= 15'h0000;
		end else if (!brake_release) begin
			per_ff <= `SDS_BRK_CHK_MS;
		end else if (ms_tick) begin
			per_ff <= per_hit ? `SDS_BRK_CHK_MS : per_ff - 15'h0001;
		end
	end

	// check pulses: short check before driving, then periodic; open check as bt_ff selects
	reg bsc_ff, boc_ff;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsc_ff <= 1'b0;
			boc_ff <= 1'b0;
		end else begin
			// no periodic pulse on the edge that re-engages the brake
			bsc_ff <= rel_start || (per_hit && nxt_st != ST_PARK);
			boc_ff <= (rel_start && bt_ff != `SDS_BT_NONE) ||
				(per_hit && nxt_st != ST_PARK &&
				bt_ff == `SDS_BT_DRV);
		end
	end
	assign brake_short_chk = bsc_ff;
	assign brake_open_chk = boc_ff;

	// motor tests enabled by selection
	assign motor_open_test = (mt_ff == `SDS_MT_OPEN) ||
		(mt_ff == `SDS_MT_ALL);
	assign motor_short_test = (mt_ff == `SDS_MT_SHORT) ||
		(mt_ff == `SDS_MT_ALL);

	// windows in which a sensed fault counts
	wire bo_win = (bt_ff == `SDS_BT_DRV) ? brake_release :
		((bt_ff == `SDS_BT_PRE) && st_ff == ST_REL);
	wire [3:0] flt_set = sy2_ff & {brake_release, bo_win,
		motor_short_test, motor_open_test};
	wire [3:0] flt_clr = (wr && paddr == `SDS_OFS_FLT) ?
		pwdata[3:0] : 4'h0;

	// register writes and sticky faults; a new fault beats its clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mt_ff <= `SDS_MT_ALL;
			dt_ff <= 3'h0;
			bt_ff <= `SDS_BT_PRE;
			vmax_ff <= `SDS_VMAX_RST;
			ovw_ff <= `SDS_OVW_RST;
			ovr_ff <= `SDS_OVR_RST;
			uvs_ff <= `SDS_UVS_RST;
			uve_ff <= `SDS_UVE_RST;
			eng_ff <= `SDS_ENG_RST;
			rel_ff <= `SDS_REL_RST;
			flt_ff <= 4'h0;
		end else begin
			flt_ff <= (flt_ff & ~flt_clr) | flt_set;
			if (wr && paddr == `SDS_OFS_CTRL) begin
				mt_ff <= pwdata[`SDS_CTL_MT_LSB +: 2];
				// larger adjust values saturate at the top step
				dt_ff <= (pwdata[`SDS_CTL_DT_LSB +: 3] > `SDS_DT_MAX) ?
					`SDS_DT_MAX : pwdata[`SDS_CTL_DT_LSB +: 3];
				// the unused fourth code falls back to pre-drive
				bt_ff <= (pwdata[`SDS_CTL_BT_LSB +: 2] > `SDS_BT_DRV) ?
					`SDS_BT_PRE : pwdata[`SDS_CTL_BT_LSB +: 2];
			end
			if (wr && paddr == `SDS_OFS_VMAX) begin
				vmax_ff <= clampv(pwdata[9:0], `SDS_VMAX_LO,
					`SDS_VMAX_HI);
			end
			if (wr && paddr == `SDS_OFS_OV) begin
				ovw_ff <= clampv(pwdata[9:0], `SDS_OVW_LO, `SDS_OVW_HI);
				ovr_ff <= clampv(pwdata[`SDS_HI_LSB +: 10], `SDS_OVR_LO,
					`SDS_OVR_HI);
			end
			if (wr && paddr == `SDS_OFS_UV) begin
				uvs_ff <= clampv(pwdata[9:0], `SDS_UVS_LO, `SDS_UVS_HI);
				uve_ff <= clampv(pwdata[`SDS_HI_LSB +: 10], `SDS_UVE_LO,
					`SDS_UVE_HI);
			end
			if (wr && paddr == `SDS_OFS_DLY) begin
				eng_ff <= (pwdata[14:0] > `SDS_DLY_HI) ?
					`SDS_DLY_HI : pwdata[14:0];
				rel_ff <= (pwdata[`SDS_HI_LSB +: 15] > `SDS_DLY_HI) ?
					`SDS_DLY_HI : pwdata[`SDS_HI_LSB +: 15];
			end
		end
	end

	// read data is captured in the setup cycle, stable in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`SDS_OFS_CTRL: rdata_ff <= {25'h0000000, bt_ff, dt_ff, mt_ff};
				`SDS_OFS_VMAX: rdata_ff <= {22'h000000, vmax_ff};
				`SDS_OFS_OV: rdata_ff <= {6'h00, ovr_ff, 6'h00, ovw_ff};
				`SDS_OFS_UV: rdata_ff <= {6'h00, uve_ff, 6'h00, uvs_ff};
				`SDS_OFS_DLY: rdata_ff <= {1'b0, rel_ff, 1'b0, eng_ff};
				`SDS_OFS_STAT: rdata_ff <= {6'h00, vbat, lim, 4'h0, st_ff};
				`SDS_OFS_FLT: rdata_ff <= {28'h0000000, flt_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end
	end
endmodule // sds_drive_sup

//--- tb/sds_drive_sup_assertions.sv
// Purpose: port checks of the drive supervisor
// Assumes: one pclk domain, presetn async low
// Notes: thresholds sit in registers, so only port relations here
`timescale 1ns/1ns
module sds_sup_chk (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	// drive side
	input wire [9:0] vbat,
	input wire [9:0] motor_volt,
	input wire drive_en,
	input wire brake_release,
	input wire brake_open_chk,
	input wire brake_short_chk
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero-wait slave, error only in access
	pready_high_a: assert property (pready)
		else $error("pready low");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	drive_brake_a: assert property (drive_en |-> brake_release)
		else $error("drive with brake set");
	rel_first_a: assert property ($rose(brake_release) |-> !drive_en)
		else $error("drive with brake release");
	short_rel_a: assert property ($rose(brake_release) |-> brake_short_chk)
		else $error("no short check at release");
	short_win_a: assert property (brake_short_chk |-> brake_release)
		else $error("short check while parked");
	open_win_a: assert property (brake_open_chk |-> brake_release)
		else $error("open check while parked");
	// two idle cycles let the registered voltage settle to zero
	volt_idle_a: assert property (!drive_en [*2] |-> motor_volt == 10'h000)
		else $error("voltage without drive");
	volt_bat_a: assert property ($stable(vbat) &&
		$past(vbat, 2) == $past(vbat) |-> motor_volt <= vbat)
		else $error("voltage above battery");
endmodule // sds_sup_chk
bind sds_drive_sup sds_sup_chk sds_sup_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .vbat(vbat), .motor_volt(motor_volt),
	.drive_en(drive_en), .brake_release(brake_release),
	.brake_open_chk(brake_open_chk), .brake_short_chk(brake_short_chk));

//--- tb/sds_far_side.sv
// Purpose: motor, brake and sense model beyond the bridge
// Assumes: wheel speed follows the bridge voltage one cycle late
// Notes: faults show only on commanded bits, brake faults only while the brake is released
`timescale 1ns/1ns
module sds_far_side (
	// clock
	input wire pclk,
	// from the supervisor
	input wire [9:0] motor_volt,
	input wire brake_release,
	// bench fault commands
	input wire [3:0] bad,
	// to the supervisor
	output wire stopped,
	output wire [3:0] flt_pin
);
	logic [9:0] spd_ff = 10'h000; // wheel speed
	// wheel follows voltage
	always @(posedge pclk) begin
		spd_ff <= motor_volt;
	end
	assign stopped = (spd_ff == 10'h000);
	// brake faults are sensed only while the coil is driven
	assign flt_pin = bad & {brake_release, brake_release, 2'b11};
endmodule // sds_far_side

//--- tb/tb_scooter_drive_supervisor.sv
// Purpose: register and drive sequence bench of the supervisor
// Assumes: one ms is ten pclk cycles here
// Notes: delay windows allow one ms of tick phase
`timescale 1ns/1ns
module tb_scooter_drive_supervisor;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, demand = 0, dt_calib = 8'h40, p;
	logic [31:0] pwdata = 0, rv;
	logic [9:0] vbat = 10'h0f0;
	logic [3:0] bad = 0;
	logic se;
	wire pready, pslverr, stopped, drive_en, brake_release;
	wire mo, ms, boc, bsc;
	wire [31:0] prdata;
	wire [9:0] motor_volt;
	wire [7:0] dead_time;
	wire [3:0] flt_pin;
	int err_total = 0, num_checks = 0, cyc = 0, k;
	sds_drive_sup #(.MS_CYCLES(10)) sds_drive_sup_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.demand(demand), .stopped(stopped), .vbat(vbat),
		.dt_calib(dt_calib), .flt_pin(flt_pin),
		.motor_volt(motor_volt), .drive_en(drive_en),
		.brake_release(brake_release), .dead_time(dead_time),
		.motor_open_test(mo), .motor_short_test(ms),
		.brake_open_chk(boc), .brake_short_chk(bsc));
	sds_far_side sds_far_side_inst (.pclk(pclk),
		.motor_volt(motor_volt), .brake_release(brake_release),
		.bad(bad), .stopped(stopped), .flt_pin(flt_pin));
	// 125 MHz clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results;
		end
	end
	task results;
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// bounded wait on drive_en (s=0) or brake_release (s=1)
	task wt(input int s, input logic v);
		for (int n = 0; n < 200; n++) begin
			@(posedge pclk);
			if ((s == 0 ? drive_en : brake_release) === v) break;
		end
	endtask
	task hold(input int n);
		repeat (n) @(posedge pclk);
	endtask
	initial begin
		hold(20);
		presetn <= 1;
		xfer(0, 8'h00, 0); ck(rv, 32'h23);
		xfer(0, 8'h04, 0); ck(rv, 32'h120);
		xfer(0, 8'h08, 0); ck(rv, 32'h0156012e);
		xfer(0, 8'h0c, 0); ck(rv, 32'h00b400d2);
		xfer(0, 8'h10, 0); ck(rv, 32'h7d0);
		xfer(0, 8'h1c, 0); ck(se, 1);
		ck(rv, 0);
		// every motor test selection
		for (k = 0; k < 4; k++) begin
			xfer(1, 8'h00, 32'h20 | k);
			hold(1);
			ck({ms, mo}, k);
		end
		// each adjust step lengthens dead-time
		for (k = 0; k < 5; k++) begin
			xfer(1, 8'h00, 32'h23 | (k << 2));
			// dead_time is registered behind the field, so let it settle
			hold(2);
			if (k == 0) ck(dead_time, 8'h40);
			else ck(dead_time > p, 1);
			p = dead_time;
		end
		xfer(1, 8'h00, 32'h3f);
		xfer(0, 8'h00, 0); ck(rv, 32'h33);
		// drive under a low voltage cap
		xfer(1, 8'h10, 32'h2);
		xfer(1, 8'h04, 32'd100);
		vbat <= 10'd240;
		demand <= 8'hff;
		wt(0, 1);
		hold(12);
		ck(motor_volt <= 100 && motor_volt >= 98, 1);
		xfer(1, 8'h04, 32'h1ff);
		xfer(0, 8'h04, 0); ck(rv, 32'h192);
		hold(4);
		ck(motor_volt <= 240 && motor_volt >= 238, 1);
		// battery thresholds seen in the throttle limit
		vbat <= 10'd310;
		hold(30);
		xfer(0, 8'h14, 0); ck(rv[15:8], 8'h7f);
		vbat <= 10'd345;
		hold(30);
		ck(motor_volt, 0);
		vbat <= 10'd195;
		hold(30);
		xfer(0, 8'h14, 0); ck(rv[15:8], 8'h7f);
		vbat <= 10'd179;
		hold(30);
		xfer(0, 8'h14, 0); ck(rv[15:8], 8'h00);
		// engage after the neutral delay
		vbat <= 10'd240;
		demand <= 0;
		hold(8);
		ck(brake_release, 1);
		wt(1, 0);
		ck(brake_release, 0);
		// release at once, drive after three ms
		xfer(1, 8'h10, 32'h00030002);
		demand <= 8'h40;
		hold(2);
		ck(brake_release, 1);
		ck(bsc, 1);
		ck(boc, 1);
		hold(15);
		ck(drive_en, 0);
		wt(0, 1);
		ck(drive_en, 1);
		// brake short while driving parks the scooter
		bad <= 4'h8;
		wt(1, 0);
		ck(brake_release, 0);
		xfer(0, 8'h18, 0); ck(rv[3:0], 4'h8);
		bad <= 0;
		xfer(1, 8'h18, 32'hf);
		xfer(0, 8'h18, 0); ck(rv[3:0], 4'h0);
		// open brake ignored with no test, caught while driving
		xfer(1, 8'h00, 32'h03);
		bad <= 4'h4;
		wt(0, 1);
		hold(5);
		xfer(0, 8'h18, 0); ck(rv[2], 0);
		xfer(1, 8'h00, 32'h43);
		hold(5);
		xfer(0, 8'h18, 0); ck(rv[2], 1);
		// open brake caught while releasing in pre-drive mode
		xfer(1, 8'h00, 32'h23);
		xfer(1, 8'h18, 32'hf);
		hold(5);
		xfer(0, 8'h18, 0); ck(rv[2], 1);
		ck(brake_release, 0);
		results;
	end
endmodule // tb_scooter_drive_supervisor
